// File: core/tpu_ctl_if.sv
// interface: control signals between register file, prescaler and counter
`timescale 1ns/100ps
`default_nettype none
interface tpu_ctl_if;
  logic       prescaler_run;
  logic [2:0] base_select;
  logic [1:0] count_clock_select;
  logic       tick;
  logic       base_selected;
  modport regs (output prescaler_run, output base_select, output count_clock_select);
  modport pre  (input prescaler_run, input base_select, input count_clock_select,
                output tick, output base_selected);
  modport cnt  (input tick, input base_selected);
endinterface
`default_nettype wire

// File: core/tpu_pkg.sv
// package: register map, field positions, reset values, prescaler constants
package tpu_pkg;
  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_RUN      = 12'h004;
  localparam logic [11:0] ADDR_RESTART  = 12'h008;
  localparam logic [11:0] ADDR_CYCLE    = 12'h00c;
  localparam logic [11:0] ADDR_COUNTER  = 12'h010;
  localparam logic [11:0] ADDR_CLKCFG   = 12'h014;
  localparam int CLKSEL_LSB     = 0;
  localparam int RUN_BIT        = 0;
  localparam int PRUN_BIT       = 1;
  localparam int RESTART_BIT    = 0;
  localparam int PRCK_LSB       = 0;
  localparam int DIV_WIDTH      = 9;
  localparam logic [2:0]  PRCK_MAX       = 3'h5;
  localparam logic [1:0]  CLKSEL_RESET   = 2'h0;
  localparam logic [2:0]  PRCK_RESET     = 3'h0;
  localparam logic [15:0] CYCLE_RESET    = 16'hffff;
  localparam logic [15:0] COUNTER_RESET  = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
endpackage

// File: core/tpu_prescaler.sv
// prescaler: free divider producing one-cycle tick on selected tap
`timescale 1ns/100ps
`default_nettype none
module tpu_prescaler
  import tpu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  tpu_ctl_if.pre    ctl
);
  logic [DIV_WIDTH-1:0] div;
  logic [DIV_WIDTH-1:0] next_div;
  logic [3:0]           shift;

  // divider stops and clears when prescaler is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= '0;
    else if (!ctl.prescaler_run)
      div <= '0;
    else
      div <= next_div;
  end
  assign next_div = div + {{(DIV_WIDTH-1){1'b0}}, 1'b1};

  // tap rate = fperiph / 2^(base_select + count_clock_select)
  always_comb
  begin
    shift = {1'b0, ctl.base_select} + {2'b00, ctl.count_clock_select};
  end

  function automatic logic tap_tick(input logic [DIV_WIDTH-1:0] d, input logic [3:0] s);
    logic [DIV_WIDTH-1:0] mask;
    mask = DIV_WIDTH'((1 << s) - 1);
    return (d & mask) == mask;
  endfunction

  assign ctl.tick          = ctl.prescaler_run && tap_tick(div, shift);
  assign ctl.base_selected = (ctl.count_clock_select == 2'h0);

  tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl.prescaler_run && shift == 4'h1 && ctl.tick) |=> !ctl.tick ##1 (ctl.tick || !ctl.prescaler_run || shift != 4'h1))
    else $error("div2 tap period wrong");
  prescale_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl.prescaler_run |-> !ctl.tick)
    else $error("tick while prescaler off");
endmodule
`default_nettype wire

// File: core/tpu_top.sv
// top: APB registers and 16-bit up-counter with cycle match clear
//
// Design decisions made here: the APB register port; the register addresses are set in tpu_pkg.
`timescale 1ns/100ps
`default_nettype none
module tpu_top
  import tpu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [15:0]      up_counter_value,
  output logic             match_clear
);
  tpu_ctl_if ctl ();

  logic        counter_run_bit;
  logic        prescaler_run_bit;
  logic [1:0]  count_clock_select;
  logic [2:0]  base_select;
  logic [15:0] cycle_register;
  logic        restart_pulse;
  logic        match_pending;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [15:0] next_count;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    return a == ref_a;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = is_addr(paddr, ADDR_CONTROL) || is_addr(paddr, ADDR_RUN) ||
                  is_addr(paddr, ADDR_RESTART) || is_addr(paddr, ADDR_CYCLE) ||
                  is_addr(paddr, ADDR_COUNTER) || is_addr(paddr, ADDR_CLKCFG);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_run_bit    <= 1'b0;
      prescaler_run_bit  <= 1'b0;
      count_clock_select <= CLKSEL_RESET;
      base_select        <= PRCK_RESET;
      cycle_register     <= CYCLE_RESET;
    end
    else if (wr)
    begin
      if (is_addr(paddr, ADDR_CONTROL))
        count_clock_select <= pwdata[CLKSEL_LSB +: 2];
      if (is_addr(paddr, ADDR_RUN))
      begin
        counter_run_bit   <= pwdata[RUN_BIT];
        prescaler_run_bit <= pwdata[PRUN_BIT];
      end
      if (is_addr(paddr, ADDR_CYCLE))
        cycle_register <= pwdata[15:0];
      if (is_addr(paddr, ADDR_CLKCFG) && pwdata[PRCK_LSB +: 3] <= PRCK_MAX)
        base_select <= pwdata[PRCK_LSB +: 3];
    end
  end

  // restart is a write-one pulse, reads back zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restart_pulse <= 1'b0;
    else
      restart_pulse <= wr && is_addr(paddr, ADDR_RESTART) && pwdata[RESTART_BIT];
  end

  assign ctl.prescaler_run      = prescaler_run_bit;
  assign ctl.base_select        = base_select;
  assign ctl.count_clock_select = count_clock_select;

  tpu_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl)
  );

  // read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= UNMAPPED_READ;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADDR_CONTROL: prdata <= {30'h0000_0000, count_clock_select};
        ADDR_RUN:     prdata <= {30'h0000_0000, prescaler_run_bit, counter_run_bit};
        ADDR_CYCLE:   prdata <= {16'h0000, cycle_register};
        ADDR_COUNTER: prdata <= {16'h0000, up_counter_value};
        ADDR_CLKCFG:  prdata <= {29'h0000_0000, base_select};
        default:      prdata <= UNMAPPED_READ;
      endcase
    end
  end

  assign next_count = up_counter_value + 16'h0001;

  // counter: base tap needs match tick then clear tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_counter_value <= COUNTER_RESET;
      match_pending    <= 1'b0;
      match_clear      <= 1'b0;
    end
    else
    begin
      match_clear <= 1'b0;
      if (!counter_run_bit)
      begin
        up_counter_value <= COUNTER_RESET;
        match_pending    <= 1'b0;
      end
      else if (restart_pulse)
      begin
        up_counter_value <= COUNTER_RESET;
        match_pending    <= 1'b0;
      end
      else if (ctl.tick)
      begin
        if (ctl.base_selected)
        begin
          if (match_pending)
          begin
            up_counter_value <= COUNTER_RESET;
            match_pending    <= 1'b0;
            match_clear      <= 1'b1;
          end
          else if (up_counter_value == cycle_register)
            match_pending <= 1'b1;
          else
            up_counter_value <= next_count;
        end
        else if (up_counter_value == cycle_register)
        begin
          up_counter_value <= COUNTER_RESET;
          match_clear      <= 1'b1;
        end
        else
          up_counter_value <= next_count;
      end
    end
  end

  stop_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_run_bit |=> up_counter_value == 16'h0000)
    else $error("counter not cleared while stopped");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_run_bit && !restart_pulse && ctl.tick && !ctl.base_selected &&
     up_counter_value != cycle_register) |=> up_counter_value == $past(up_counter_value) + 16'h0001)
    else $error("counter did not step");
  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_run_bit && !restart_pulse && !ctl.tick) |=> $stable(up_counter_value))
    else $error("counter moved without tick");
  restart_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_run_bit && restart_pulse) |=> up_counter_value == 16'h0000)
    else $error("restart did not clear");
  match_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_clear |-> up_counter_value == 16'h0000)
    else $error("match without clear");
  slow_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_run_bit && !restart_pulse && ctl.tick && !ctl.base_selected &&
     up_counter_value == cycle_register) |=> match_clear)
    else $error("slow tap match missed");
  base_two_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_run_bit && !restart_pulse && ctl.tick && ctl.base_selected && !match_pending &&
     up_counter_value == cycle_register) |=> match_pending && !match_clear)
    else $error("base tap cleared too early");
  run_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && is_addr(paddr, ADDR_RUN)) |=> counter_run_bit == $past(pwdata[RUN_BIT]))
    else $error("run bit not written");

  run_c: cover property (@(posedge pclk) disable iff (!presetn) counter_run_bit && ctl.tick);
  match_c: cover property (@(posedge pclk) disable iff (!presetn) match_clear && ctl.base_selected);
  restart_c: cover property (@(posedge pclk) disable iff (!presetn) restart_pulse && counter_run_bit);
endmodule
`default_nettype wire

// File: verif/tpu_top_test.sv
// testbench: taps, run, restart and match clear over APB
`timescale 1ns/100ps
`default_nettype none
module tpu_top_test;
  import tpu_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] up_counter_value;
  logic        match_clear;
  logic [31:0] rd;
  logic        err;
  int          mismatches;
  int          n_compared;
  int          n0;
  int          n1;
  tpu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .up_counter_value(up_counter_value), .match_clear(match_clear));
  always #20 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang(input string what);
    mismatches++;
    $display("unexpected at %0t: no end of %s", $time, what);
    conclude;
  endtask
  // one APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
      hang("transfer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask
  // cycles between two successive counter changes or match pulses
  task automatic span(input logic on_match, output int n);
    logic [15:0] prev;
    int          i;
    int          hits;
    prev = up_counter_value;
    n = 1;
    hits = 0;
    for (i = 0; i < 2000 && hits < 2; i++)
    begin
      @(posedge pclk);
      if (on_match ? match_clear === 1'b1 : up_counter_value !== prev)
        hits++;
      else if (hits == 1)
        n++;
      prev = up_counter_value;
    end
    if (hits < 2)
      hang("period");
  endtask
  task automatic reset_values;
    apb(0, ADDR_CYCLE, 0);
    check(rd, 32'h0000_ffff, "cycle");
    apb(0, ADDR_COUNTER, 0);
    check(rd, 32'h0000_0000, "counter");
    apb(0, ADDR_RUN, 0);
    check(rd, 32'h0000_0000, "run");
    apb(0, 12'h020, 0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0000_0000, "unmapped data");
    $display("reset values done");
  endtask
  task automatic taps;
    int c;
    int n;
    for (c = 0; c < 9; c++)
    begin
      apb(1, ADDR_RUN, 32'h0000_0000);
      apb(1, ADDR_CLKCFG, c < 6 ? c : 2);
      apb(1, ADDR_CONTROL, c < 6 ? 0 : c - 5);
      apb(1, ADDR_RUN, 32'h0000_0003);
      span(1'b0, n);
      check(n, 1 << (c < 6 ? c : c - 3), "tap period");
    end
    apb(1, ADDR_RUN, 32'h0000_0001);
    apb(0, ADDR_COUNTER, 0);
    n = rd;
    repeat (40) @(posedge pclk);
    apb(0, ADDR_COUNTER, 0);
    check(rd, n, "frozen without prescaler");
    $display("taps done");
  endtask
  task automatic stop_restart;
    apb(1, ADDR_CLKCFG, 0);
    apb(1, ADDR_CONTROL, 0);
    apb(1, ADDR_RUN, 32'h0000_0003);
    repeat (30) @(posedge pclk);
    apb(1, ADDR_RESTART, 1);
    apb(0, ADDR_COUNTER, 0);
    check(rd < 8, 1'b1, "restart clears");
    repeat (20) @(posedge pclk);
    apb(0, ADDR_COUNTER, 0);
    check(rd > 16, 1'b1, "restart keeps counting");
    apb(1, ADDR_RUN, 32'h0000_0002);
    repeat (5) @(posedge pclk);
    apb(0, ADDR_COUNTER, 0);
    check(rd, 32'h0000_0000, "stop clears");
    check(up_counter_value, 16'h0000, "stop holds");
    $display("stop and restart done");
  endtask
  task automatic match_period;
    apb(1, ADDR_CYCLE, 3);
    apb(1, ADDR_RUN, 32'h0000_0003);
    span(1'b1, n0);
    apb(1, ADDR_RUN, 32'h0000_0002);
    apb(1, ADDR_CONTROL, 1);
    apb(1, ADDR_RUN, 32'h0000_0003);
    span(1'b1, n1);
    check(n0, n1 / 2 + 1, "base tap one extra count");
    $display("match period done");
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values;
    taps;
    stop_restart;
    match_period;
    conclude;
  end
endmodule
`default_nettype wire
